// >>> verilog/scs_sequencer.sv
// Serial configuration sequencer with an APB register slave.
`include "scs_cfg.svh"

module scs_sequencer #(
    parameter int ADDR_W = 12,
    parameter int POR_CYCLES = `SCS_US2CYC_UP(`SCS_POR_DELAY_US),
    parameter int STATUS_LOW_CYCLES =
        `SCS_US2CYC_UP(`SCS_STATUS_LOW_MIN_US),
    parameter int INIT_OSC_CYCLES =
        `SCS_US2CYC_UP((`SCS_INIT_MIN_US + `SCS_INIT_MAX_US) / 2),
    parameter int USER_INIT_CYCLES = `SCS_USER_INIT_CYCLES
) (
    // Clock and reset
    input wire logic CORE_CLK_I,
    input wire logic RESET_I,
    // APB slave
    input wire logic PSEL_I,
    input wire logic PENABLE_I,
    input wire logic PWRITE_I,
    input wire logic [ADDR_W-1:0] PADDR_I,
    input wire logic [31:0] PWDATA_I,
    output logic [31:0] PRDATA_O,
    output logic PREADY_O,
    output logic PSLVERR_O,
    // Request and open-drain status and completion lines
    input wire logic CONFIG_REQUEST_N_I,
    input wire logic CONFIG_STATUS_N_I,
    output logic CONFIG_STATUS_N_O,
    output logic CONFIG_STATUS_N_OE_O,
    input wire logic CONFIG_COMPLETE_I,
    output logic CONFIG_COMPLETE_O,
    output logic CONFIG_COMPLETE_OE_O,
    // Configuration clock, host-driven in passive mode
    input wire logic CONFIG_CLOCK_I,
    output logic CONFIG_CLOCK_O,
    output logic CONFIG_CLOCK_OE_O,
    // Serial data pins
    input wire logic SERIAL_CONFIG_DATA_I,
    input wire logic [3:0] FLASH_DATA_LINES_I,
    output logic FLASH_SERIAL_OUT_O,
    // Initialization
    input wire logic USER_CLOCK_I,
    output logic INIT_DONE_O,
    output logic INIT_DONE_OE_O,
    // User side
    output logic [3:0] CFG_DATA_O,
    output logic CFG_VALID_O,
    output logic USER_MODE_O,
    output logic USER_DATA_O,
    output scs_pkg::scs_state_t SEQ_STATE_O
);
    import scs_pkg::*;

    localparam logic [23:0] POR_C = 24'(POR_CYCLES);
    localparam logic [23:0] STAT_LOW_C = 24'(STATUS_LOW_CYCLES);
    localparam logic [23:0] OSC_C = 24'(INIT_OSC_CYCLES);
    localparam logic [23:0] USER_C = 24'(USER_INIT_CYCLES);
    localparam logic [23:0] CU_C = 24'(`SCS_CU_CYCLES);
    localparam logic [2:0] HALF0 = 3'(`SCS_HALF_UP(`SCS_RATE0_KHZ));
    localparam logic [2:0] HALF1 = 3'(`SCS_HALF_UP(`SCS_RATE1_KHZ));
    localparam logic [2:0] HALF2 = 3'(`SCS_HALF_UP(`SCS_RATE2_KHZ));
    localparam logic [2:0] HALF3 = 3'(`SCS_HALF_UP(`SCS_RATE3_KHZ));

    // Pin synchronisation; the completion input is only reported.
    logic [9:0] pin_raw;
    logic [9:0] pin_s;
    logic req_n_s, stat_n_s, config_clock_s, data_s, uclk_s, done_s;
    logic [3:0] flash_s;

    assign pin_raw = {CONFIG_COMPLETE_I, CONFIG_REQUEST_N_I,
                      CONFIG_STATUS_N_I, CONFIG_CLOCK_I,
                      SERIAL_CONFIG_DATA_I, FLASH_DATA_LINES_I,
                      USER_CLOCK_I};
    assign {done_s, req_n_s, stat_n_s, config_clock_s, data_s, flash_s,
            uclk_s} = pin_s;

    scs_sync #(.WIDTH(10)) u_sync (
        .clk_i(CORE_CLK_I),
        .reset_i(RESET_I),
        .d_i(pin_raw),
        .q_o(pin_s)
    );

    logic config_clock_d_r, uclk_d_r;
    logic config_clock_rise, config_clock_fall, uclk_rise;

    always_ff @(posedge CORE_CLK_I) begin
        if (RESET_I) begin
            config_clock_d_r <= 1'b0;
            uclk_d_r <= 1'b0;
        end else begin
            config_clock_d_r <= config_clock_s;
            uclk_d_r <= uclk_s;
        end
    end

    assign config_clock_rise = config_clock_s & ~config_clock_d_r;
    assign config_clock_fall = ~config_clock_s & config_clock_d_r;
    assign uclk_rise = uclk_s & ~uclk_d_r;

    // Register file.
    logic [7:0] ctrl_r;
    logic [31:0] length_r;
    logic [7:0] cmd_r;
    logic pready_r, pslverr_r;
    logic [31:0] prdata_r, rdata_nxt;
    logic apb_acc, addr_ok, apb_wr;
    logic [31:0] bit_cnt_r;
    scs_state_t state_r, state_nxt;

    assign apb_acc = PSEL_I & PENABLE_I;
    assign apb_wr = apb_acc & pready_r & PWRITE_I & addr_ok;

    always_comb begin
        addr_ok = ~|PADDR_I[ADDR_W-1:8];
        rdata_nxt = 32'h0000_0000;
        case (PADDR_I[7:0])
            `SCS_OFS_CTRL: rdata_nxt = {24'h00_0000, ctrl_r};
            `SCS_OFS_LENGTH: rdata_nxt = length_r;
            `SCS_OFS_CMD: rdata_nxt = {24'h00_0000, cmd_r};
            `SCS_OFS_STATUS: rdata_nxt = {24'h00_0000, done_s,
                                          USER_MODE_O, state_r};
            `SCS_OFS_COUNT: rdata_nxt = bit_cnt_r;
            default: addr_ok = 1'b0;
        endcase
        if (!addr_ok) begin
            rdata_nxt = 32'h0000_0000;
        end
    end

    // One wait state: the answer is prepared in the first access cycle.
    always_ff @(posedge CORE_CLK_I) begin
        if (RESET_I) begin
            pready_r <= 1'b0;
            pslverr_r <= 1'b0;
            prdata_r <= 32'h0000_0000;
        end else begin
            pready_r <= apb_acc & ~pready_r;
            if (apb_acc & ~pready_r) begin
                pslverr_r <= ~addr_ok;
                prdata_r <= PWRITE_I ? 32'h0000_0000 : rdata_nxt;
            end else begin
                pslverr_r <= 1'b0;
            end
        end
    end

    always_ff @(posedge CORE_CLK_I) begin
        if (RESET_I) begin
            ctrl_r <= `SCS_CTRL_RESET;
            length_r <= `SCS_LENGTH_RESET;
            cmd_r <= `SCS_CMD_RESET;
        end else if (apb_wr) begin
            case (PADDR_I[7:0])
                `SCS_OFS_CTRL: ctrl_r <= PWDATA_I[7:0];
                `SCS_OFS_LENGTH: length_r <= PWDATA_I;
                `SCS_OFS_CMD: cmd_r <= PWDATA_I[7:0];
                default: ;
            endcase
        end
    end

    // Decoded options.
    logic [1:0] mode, rate, rate_eff;
    logic is_ps, is_x4, init_user;

    assign mode = ctrl_r[`SCS_CTRL_MODE_LO +: 2];
    assign rate = ctrl_r[`SCS_CTRL_RATE_LO +: 2];
    assign is_ps = (mode == MODE_PS);
    assign is_x4 = (mode == MODE_AS4);
    assign init_user = ctrl_r[`SCS_CTRL_INIT_USER];
    // A chain cannot run at the top rate, so it falls back one step.
    assign rate_eff = (ctrl_r[`SCS_CTRL_MULTI] && rate == 2'h3) ?
                      2'h2 : rate;

    // Counters and sequencing.
    logic [23:0] por_cnt_r, stat_cnt_r, init_cnt_r, uclk_cnt_r;
    logic [1:0] falls_r;
    logic bit_done, init_ready, as_en, as_fall, clk_fall;
    logic as_clk_r;
    logic [2:0] half_cnt_r, half_sel;
    logic [3:0] cmd_left_r;

    assign bit_done = (bit_cnt_r >= length_r);
    assign init_ready = init_user ? (uclk_cnt_r >= USER_C)
                                  : (init_cnt_r >= OSC_C);
    assign clk_fall = is_ps ? config_clock_fall : as_fall;

    always_comb begin
        state_nxt = state_r;
        case (state_r)
            ST_POR: begin
                if (por_cnt_r >= POR_C) state_nxt = ST_CLEAR;
            end
            ST_CLEAR: begin
                if (req_n_s && stat_cnt_r >= STAT_LOW_C) begin
                    state_nxt = ST_RELEASE;
                end
            end
            ST_RELEASE: begin
                // An external low on the status line delays loading.
                if (stat_n_s) state_nxt = ST_LOAD;
            end
            ST_LOAD: begin
                if (bit_done) state_nxt = ST_INIT;
            end
            ST_INIT: begin
                if (falls_r == 2'h2 && init_ready) begin
                    state_nxt = ST_USER;
                end
            end
            ST_USER: ;
            default: state_nxt = ST_POR;
        endcase
        if (state_r != ST_POR && !req_n_s) begin
            state_nxt = ST_CLEAR;
        end
    end

    always_ff @(posedge CORE_CLK_I) begin
        if (RESET_I) begin
            state_r <= ST_POR;
        end else begin
            state_r <= state_nxt;
        end
    end

    always_ff @(posedge CORE_CLK_I) begin
        if (RESET_I) begin
            por_cnt_r <= 24'h00_0000;
            stat_cnt_r <= 24'h00_0000;
        end else begin
            if (state_r == ST_POR && por_cnt_r != POR_C) begin
                por_cnt_r <= por_cnt_r + 24'h00_0001;
            end
            if (state_r != ST_CLEAR) begin
                stat_cnt_r <= 24'h00_0000;
            end else if (stat_cnt_r != STAT_LOW_C) begin
                stat_cnt_r <= stat_cnt_r + 24'h00_0001;
            end
        end
    end

    // Active serial clock divider; idle low outside loading and initialization.
    assign as_en = ~is_ps & (state_r == ST_LOAD || state_r == ST_INIT);

    always_comb begin
        case (rate_eff)
            2'h0: half_sel = HALF0;
            2'h1: half_sel = HALF1;
            2'h2: half_sel = HALF2;
            default: half_sel = HALF3;
        endcase
    end

    assign as_fall = as_en & as_clk_r & (half_cnt_r >= half_sel - 3'h1);

    always_ff @(posedge CORE_CLK_I) begin
        if (RESET_I || !as_en) begin
            as_clk_r <= 1'b0;
            half_cnt_r <= 3'h0;
        end else if (half_cnt_r >= half_sel - 3'h1) begin
            as_clk_r <= ~as_clk_r;
            half_cnt_r <= 3'h0;
        end else begin
            half_cnt_r <= half_cnt_r + 3'h1;
        end
    end

    // Command out on falling edges, then data sampled on falling edges.
    // Sampling uses synchronised lines, so the flash must hold its data
    // for several core cycles; the top rate is limited by the divider.
    logic [7:0] cmd_sh_r;
    logic flash_out_r;

    always_ff @(posedge CORE_CLK_I) begin
        if (RESET_I) begin
            cmd_sh_r <= 8'h00;
            cmd_left_r <= 4'h0;
            flash_out_r <= 1'b0;
        end else if (state_r != ST_LOAD) begin
            flash_out_r <= cmd_r[7];
            cmd_sh_r <= {cmd_r[6:0], 1'b0};
            cmd_left_r <= 4'h8;
        end else if (as_fall && cmd_left_r != 4'h0) begin
            flash_out_r <= cmd_sh_r[7];
            cmd_sh_r <= {cmd_sh_r[6:0], 1'b0};
            cmd_left_r <= cmd_left_r - 4'h1;
        end
    end

    // Bit capture.
    logic ps_take, as_take;
    logic [3:0] cfg_data_r;
    logic cfg_valid_r;

    // Clock edges count only once status is released.
    assign ps_take = is_ps & config_clock_rise & stat_n_s;
    assign as_take = ~is_ps & as_fall & (cmd_left_r == 4'h0);

    always_ff @(posedge CORE_CLK_I) begin
        if (RESET_I || state_r != ST_LOAD) begin
            bit_cnt_r <= (RESET_I) ? 32'h0000_0000 :
                         (state_r == ST_RELEASE ? 32'h0000_0000 : bit_cnt_r);
            cfg_valid_r <= 1'b0;
            cfg_data_r <= 4'h0;
        end else if ((ps_take || as_take) && !bit_done) begin
            cfg_valid_r <= 1'b1;
            if (as_take && is_x4) begin
                cfg_data_r <= flash_s;
                bit_cnt_r <= bit_cnt_r + 32'h0000_0004;
            end else begin
                cfg_data_r <= {3'h0, ps_take ? data_s : flash_s[0]};
                bit_cnt_r <= bit_cnt_r + 32'h0000_0001;
            end
        end else begin
            cfg_valid_r <= 1'b0;
        end
    end

    // Initialization timing from the completion rise.
    always_ff @(posedge CORE_CLK_I) begin
        if (RESET_I || state_r != ST_INIT) begin
            init_cnt_r <= 24'h00_0000;
            uclk_cnt_r <= 24'h00_0000;
            falls_r <= 2'h0;
        end else begin
            if (init_cnt_r != 24'hff_ffff) begin
                init_cnt_r <= init_cnt_r + 24'h00_0001;
            end
            if (clk_fall && falls_r != 2'h2) begin
                falls_r <= falls_r + 2'h1;
            end
            // The start-up clock is ignored until the enable delay ends.
            if (init_user && init_cnt_r >= CU_C && uclk_rise &&
                uclk_cnt_r != USER_C) begin
                uclk_cnt_r <= uclk_cnt_r + 24'h00_0001;
            end
        end
    end

    // Registered pin and user outputs.
    logic status_oe_r, complete_oe_r, init_oe_r, user_mode_r;
    logic clk_oe_r, user_data_r, pin_low_r;

    always_ff @(posedge CORE_CLK_I) begin
        if (RESET_I) begin
            status_oe_r <= 1'b1;
            complete_oe_r <= 1'b1;
            init_oe_r <= 1'b0;
            user_mode_r <= 1'b0;
            clk_oe_r <= 1'b0;
            user_data_r <= 1'b0;
            pin_low_r <= 1'b0;
        end else begin
            status_oe_r <= (state_nxt == ST_POR ||
                            state_nxt == ST_CLEAR);
            complete_oe_r <= !(state_nxt == ST_INIT ||
                               state_nxt == ST_USER);
            init_oe_r <= ctrl_r[`SCS_CTRL_INIT_DONE_EN] &&
                         state_nxt == ST_INIT;
            user_mode_r <= (state_nxt == ST_USER);
            clk_oe_r <= as_en;
            user_data_r <= (state_r == ST_USER) &&
                           ctrl_r[`SCS_CTRL_DUAL_USER] && data_s;
            pin_low_r <= 1'b0;
        end
    end

    assign PRDATA_O = prdata_r;
    assign PREADY_O = pready_r;
    assign PSLVERR_O = pslverr_r;
    assign CONFIG_STATUS_N_O = pin_low_r;
    assign CONFIG_STATUS_N_OE_O = status_oe_r;
    assign CONFIG_COMPLETE_O = pin_low_r;
    assign CONFIG_COMPLETE_OE_O = complete_oe_r;
    assign CONFIG_CLOCK_O = as_clk_r;
    assign CONFIG_CLOCK_OE_O = clk_oe_r;
    assign FLASH_SERIAL_OUT_O = flash_out_r;
    assign INIT_DONE_O = pin_low_r;
    assign INIT_DONE_OE_O = init_oe_r;
    assign CFG_DATA_O = cfg_data_r;
    assign CFG_VALID_O = cfg_valid_r;
    assign USER_MODE_O = user_mode_r;
    assign USER_DATA_O = user_data_r;
    assign SEQ_STATE_O = state_r;

    // Checks.
    default clocking cb @(posedge CORE_CLK_I); endclocking
    default disable iff (RESET_I);

    sequence s_load_to_init;
        state_r == ST_LOAD ##1 state_r == ST_INIT;
    endsequence

    a_req_pulls_low: assert property (
        (state_r != ST_POR && !req_n_s) |=> (status_oe_r && complete_oe_r))
        else $error("request low did not pull status and completion low");
    a_status_min_low: assert property (
        $rose(state_r == ST_RELEASE) |-> $past(stat_cnt_r) >= STAT_LOW_C)
        else $error("status released before its minimum low time");
    a_status_release: assert property (
        (state_r == ST_CLEAR && req_n_s && stat_cnt_r >= STAT_LOW_C)
        |=> (state_r == ST_RELEASE && !status_oe_r))
        else $error("status not released after request rose");
    a_por_hold: assert property (
        (state_r == ST_POR) |-> status_oe_r)
        else $error("status not held low during power-on delay");
    a_complete_low: assert property (
        (state_r == ST_LOAD || state_r == ST_RELEASE) |-> complete_oe_r)
        else $error("completion released during loading");
    a_complete_bits: assert property (
        s_load_to_init |-> ($past(bit_done) && !complete_oe_r))
        else $error("completion rose before all bits arrived");
    a_ps_capture: assert property (
        (state_r == ST_LOAD && ps_take && !bit_done)
        |=> (cfg_valid_r && cfg_data_r[0] == $past(data_s)))
        else $error("passive data not captured on clock rise");
    a_osc_init: assert property (
        ($rose(state_r == ST_USER) && !$past(init_user))
        |-> ($past(init_cnt_r) >= OSC_C && $past(falls_r) == 2'h2))
        else $error("user mode entered too early with oscillator init");
    a_user_clk_init: assert property (
        ($rose(state_r == ST_USER) && $past(init_user))
        |-> $past(uclk_cnt_r) >= USER_C)
        else $error("user mode entered before start-up clock count");
    a_x4_sample: assert property (
        (state_r == ST_LOAD && as_take && is_x4 && !bit_done)
        |=> (cfg_data_r == $past(flash_s) && cfg_valid_r))
        else $error("four-bit flash data not taken");
    a_rate_cap: assert property (
        ctrl_r[`SCS_CTRL_MULTI] |-> rate_eff != 2'h3)
        else $error("top rate used with multi-device chain");
endmodule : scs_sequencer

// >>> verilog/scs_cfg.svh
// Constants of the serial configuration sequencer: offsets, fields, timing.
// Functional notes
// - Request low in user mode restarts configuration.
// - Request fall pulls completion and status low.
// - Status stays low 268 us minimum.
// - Status released after request high, unless held.
// - Status held low through power-on delay.
// - Completion low until all data received.
// - Completion rises only after every bit arrives.
// - Passive mode samples data on clock rise.
// - Data pin becomes user I/O afterwards.
// - Init-done pin driven low until initialization ends.
// - Oscillator init: user mode 175..437 us later.
// - Start-up clock: delay, then 8576 cycles.
// - Four active clock rates, each doubling; the divider gives the top two the same 50 MHz clock.
// - Highest rate barred for multi-device chains.
// - Four-bit mode takes four bits per cycle.
// - Active mode shifts and samples on falling edge.
// - Init clock: oscillator or start-up clock input.
`ifndef SCS_CFG_SVH
`define SCS_CFG_SVH

`define SCS_CORE_PERIOD_NS 10
`define SCS_US2CYC_UP(us) \
    ((((us) * 1000) + `SCS_CORE_PERIOD_NS - 1) / `SCS_CORE_PERIOD_NS)

`define SCS_POR_DELAY_US 100
`define SCS_STATUS_LOW_MIN_US 268
`define SCS_INIT_MIN_US 175
`define SCS_INIT_MAX_US 437
`define SCS_CU_PERIODS 4
`define SCS_SLOW_CLK_PERIOD_NS 80
`define SCS_CU_CYCLES \
    (((`SCS_CU_PERIODS * `SCS_SLOW_CLK_PERIOD_NS) + \
    `SCS_CORE_PERIOD_NS - 1) / `SCS_CORE_PERIOD_NS)
`define SCS_USER_INIT_CYCLES 8576

`define SCS_RATE0_KHZ 12500
`define SCS_RATE1_KHZ 25000
`define SCS_RATE2_KHZ 50000
`define SCS_RATE3_KHZ 100000
`define SCS_HALF_UP(khz) \
    ((1000000 + (2 * (khz) * `SCS_CORE_PERIOD_NS) - 1) / \
    (2 * (khz) * `SCS_CORE_PERIOD_NS))

`define SCS_OFS_CTRL 8'h00
`define SCS_OFS_LENGTH 8'h04
`define SCS_OFS_CMD 8'h08
`define SCS_OFS_STATUS 8'h0c
`define SCS_OFS_COUNT 8'h10

`define SCS_CTRL_MODE_LO 0
`define SCS_CTRL_RATE_LO 2
`define SCS_CTRL_MULTI 4
`define SCS_CTRL_INIT_USER 5
`define SCS_CTRL_INIT_DONE_EN 6
`define SCS_CTRL_DUAL_USER 7

`define SCS_CTRL_RESET 8'h00
`define SCS_LENGTH_RESET 32'h0000_1000
`define SCS_CMD_RESET 8'h03

`endif

// >>> verilog/scs_pkg.sv
// Types shared by the serial configuration sequencer.
package scs_pkg;
    typedef enum logic [5:0] {
        ST_POR = 6'h01,
        ST_CLEAR = 6'h02,
        ST_RELEASE = 6'h04,
        ST_LOAD = 6'h08,
        ST_INIT = 6'h10,
        ST_USER = 6'h20
    } scs_state_t;

    typedef enum logic [1:0] {
        MODE_PS = 2'h0,
        MODE_AS1 = 2'h1,
        MODE_AS4 = 2'h2
    } scs_mode_t;
endpackage : scs_pkg

// >>> verilog/scs_sync.sv
// Two-stage synchroniser for a group of asynchronous pin inputs.
module scs_sync #(
    parameter int WIDTH = 1
) (
    // Clock and reset
    input wire logic clk_i,
    input wire logic reset_i,
    // Data
    input wire logic [WIDTH-1:0] d_i,
    output logic [WIDTH-1:0] q_o
);
    logic [WIDTH-1:0] meta_r;

    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            meta_r <= '0;
            q_o <= '0;
        end else begin
            meta_r <= d_i;
            q_o <= meta_r;
        end
    end
endmodule : scs_sync

// >>> testbench/scs_host.sv
// Passive serial host model that clocks one frame of bits into the device.
module scs_host (
    // Frame control
    input wire logic go_i,
    input wire logic [7:0] bits_i,
    // Lines from the device
    input wire logic status_n_i,
    input wire logic complete_i,
    // Lines to the device
    output logic clk_o,
    output logic data_o
);
    timeunit 1ns;
    timeprecision 1ps;

    // The clock idles low between frames rather than floating.
    initial begin
        clk_o = 1'b0;
        data_o = 1'b0;
    end

    task automatic pulse();
        #40 clk_o = 1'b1;
        #40 clk_o = 1'b0;
    endtask : pulse

    always @(posedge go_i) begin
        wait (status_n_i === 1'b1);
        #2000;
        for (int i = 7; i >= 0; i--) begin
            data_o = bits_i[i];
            pulse();
        end
        // Released data shows the inverse, so stale bits are not mistaken.
        data_o = ~data_o;
        wait (complete_i === 1'b1);
        pulse();
        pulse();
    end
endmodule : scs_host

// >>> testbench/serial_config_sequencer_tb.sv
// Self-checking bench for the serial configuration sequencer.
`define CHK(a, b) begin tests_run++; if ((a) !== (b)) begin errors++; \
    $display("unexpected at %0t: got %h want %h", $time, a, b); end end
module serial_config_sequencer_tb;
    timeunit 1ns;
    timeprecision 1ps;
    import scs_pkg::*;
    localparam int SL = 30;
    localparam int IO = 40;
    // The oscillator init count stands for 306 us, mid of 175..437 us.
    localparam int LO = (IO * 175 + 305) / 306;
    localparam int HI = IO * 437 / 306;
    // Enable delay of four 80 ns clock periods, then 16 two-cycle clocks.
    localparam int UC = 4 * 80 / 10 + 16 * 2;
    logic clk, rst, psel, penable, pwrite, pready, pslverr, req_n, hold;
    logic stat_oe, comp_oe, hclk, hdata, go, init_oe, umode, vld, umode_q;
    logic init_en;
    logic uclk = 1'b0;
    logic cclk, cclk_q, fso, udata, uinit;
    logic [3:0] fdata = 4'h0;
    logic [3:0] exp_n;
    logic [7:0] cmd_v;
    int cmd_n = 0;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata;
    logic [7:0] bits;
    logic [3:0] cdata;
    scs_state_t state;
    logic [3:0] q[$];
    int errors = 0;
    int tests_run = 0;
    int seed = 32'ha8e165f4;
    int lo_cnt = 0;
    int cd_cnt = 0;
    wire st_n = ~(stat_oe | hold);
    wire cd_n = ~comp_oe;

    scs_sequencer #(.POR_CYCLES(20), .STATUS_LOW_CYCLES(SL),
        .INIT_OSC_CYCLES(IO), .USER_INIT_CYCLES(16)) dut (
        .CORE_CLK_I(clk), .RESET_I(rst), .PSEL_I(psel),
        .PENABLE_I(penable), .PWRITE_I(pwrite), .PADDR_I(paddr),
        .PWDATA_I(pwdata), .PRDATA_O(prdata), .PREADY_O(pready),
        .PSLVERR_O(pslverr), .CONFIG_REQUEST_N_I(req_n),
        .CONFIG_STATUS_N_I(st_n), .CONFIG_STATUS_N_O(),
        .CONFIG_STATUS_N_OE_O(stat_oe), .CONFIG_COMPLETE_I(cd_n),
        .CONFIG_COMPLETE_O(), .CONFIG_COMPLETE_OE_O(comp_oe),
        .CONFIG_CLOCK_I(hclk), .CONFIG_CLOCK_O(cclk), .CONFIG_CLOCK_OE_O(),
        .SERIAL_CONFIG_DATA_I(hdata), .FLASH_DATA_LINES_I(fdata),
        .FLASH_SERIAL_OUT_O(fso), .USER_CLOCK_I(uclk), .INIT_DONE_O(),
        .INIT_DONE_OE_O(init_oe), .CFG_DATA_O(cdata), .CFG_VALID_O(vld),
        .USER_MODE_O(umode), .USER_DATA_O(udata), .SEQ_STATE_O(state));

    scs_host host (.go_i(go), .bits_i(bits), .status_n_i(st_n),
        .complete_i(cd_n), .clk_o(hclk), .data_o(hdata));

    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    always @(posedge clk) begin
        lo_cnt <= stat_oe ? lo_cnt + 1 : 0;
        cd_cnt <= comp_oe ? 0 : cd_cnt + 1;
        umode_q <= umode;
        uclk <= ~uclk;
        cclk_q <= cclk;
        // The flash takes command bits on the rising clock edge.
        if (cclk === 1'b1 && cclk_q === 1'b0 && cmd_n < 8) begin
            cmd_v <= {cmd_v[6:0], fso};
            cmd_n <= cmd_n + 1;
        end
        if (vld === 1'b1) begin
            exp_n = q.pop_front();
            `CHK(cdata, exp_n)
        end
        if (!rst && stat_oe === 1'b0 && lo_cnt > 0)
            `CHK(lo_cnt >= SL, 1'b1)
        if (umode === 1'b1 && umode_q === 1'b0 && uinit)
            `CHK(cd_cnt >= UC, 1'b1)
        if (umode === 1'b1 && umode_q === 1'b0 && !uinit)
            `CHK(cd_cnt >= LO && cd_cnt <= HI, 1'b1)
        if (state === ST_INIT && init_en) `CHK(init_oe, 1'b1)
        if (state === ST_LOAD) `CHK(comp_oe, 1'b1)
    end

    // Called just after a rising edge; returns one edge after release.
    task automatic apb(input logic w, input logic [11:0] a,
        input logic [31:0] d, output logic [31:0] r, output logic e);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        do @(posedge clk); while (pready !== 1'b1);
        r = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge clk);
    endtask : apb

    task automatic rd(input logic [11:0] a, input logic [31:0] x,
        input logic ex);
        logic [31:0] r;
        logic e;
        apb(1'b0, a, 32'h0, r, e);
        `CHK(r, x)
        `CHK(e, ex)
    endtask : rd

    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        logic [31:0] r;
        logic e;
        apb(1'b1, a, d, r, e);
        `CHK(e, 1'b0)
    endtask : wr

    task automatic wait_state(input scs_state_t s, input int lim);
        int n;
        n = 0;
        while (state !== s && n < lim) begin
            @(posedge clk);
            n++;
        end
        `CHK(state, s)
    endtask : wait_state

    task automatic summarize();
        $display("errors=%0d tests_run=%0d", errors, tests_run);
        if (errors == 0 && tests_run > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask : summarize

    initial begin
        #300000;
        errors++;
        summarize();
    end

    initial begin
        {psel, penable, pwrite, hold, go, init_en, uinit} = 7'h00;
        paddr = 12'h000;
        pwdata = 32'h0;
        bits = 8'h00;
        req_n = 1'b1;
        rst = 1'b1;
        repeat (6) @(posedge clk);
        `CHK(stat_oe, 1'b1)
        `CHK(comp_oe, 1'b1)
        rst <= 1'b0;
        @(posedge clk);
        rd(12'h000, 32'h0, 1'b0);
        rd(12'h004, 32'h1000, 1'b0);
        rd(12'h008, 32'h3, 1'b0);
        rd(12'h100, 32'h0, 1'b1);
        wr(12'h004, 32'h8);
        for (int k = 0; k < 3; k++) begin
            if (k > 0) begin
                // Second pass reloads serially, third from a four-bit flash.
                wr(12'h000, k == 1 ? 32'h40 : 32'hfe);
                fdata <= 4'($random(seed));
                init_en = 1'b1;
                uinit = (k == 2);
                req_n <= 1'b0;
                repeat (60) @(posedge clk);
                `CHK(stat_oe, 1'b1)
                `CHK(comp_oe, 1'b1)
                repeat (140) @(posedge clk);
                hold <= 1'b1;
                req_n <= 1'b1;
                repeat (100) @(posedge clk);
                `CHK(state, ST_RELEASE)
                `CHK(stat_oe, 1'b0)
                hold <= 1'b0;
            end
            wait_state(ST_LOAD, 300);
            bits = 8'($random(seed));
            if (k < 2) begin
                for (int i = 7; i >= 0; i--) q.push_back({3'h0, bits[i]});
                go <= 1'b1;
            end else begin
                repeat (2) q.push_back(fdata);
            end
            @(posedge clk);
            go <= 1'b0;
            wait_state(ST_USER, 1000);
            rd(12'h010, 32'h8, 1'b0);
            `CHK(q.size(), 0)
            if (k == 2) begin
                `CHK(cmd_v, 8'h03)
                `CHK(udata, hdata)
            end
        end
        summarize();
    end
endmodule : serial_config_sequencer_tb
